/* ivr_top.sv */
// Interrupt vector relocation: select bit, timed unlock, irq gating.
// Assumes AXI4-Lite master on aclk; fuses and exec pins are asynchronous.
`timescale 1ns/1ns
module ivr_top
  import ivr_pkg::*;
#(
  parameter int unsigned WINDOW_CYCLES = UNLOCK_CYCLES
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [3:0]   s_axi_awaddr,
  input  wire logic         s_axi_awvalid,
  output logic              s_axi_awready,
  input  wire logic [31:0]  s_axi_wdata,
  input  wire logic [3:0]   s_axi_wstrb,
  input  wire logic         s_axi_wvalid,
  output logic              s_axi_wready,
  output logic [1:0]        s_axi_bresp,
  output logic              s_axi_bvalid,
  input  wire logic         s_axi_bready,
  input  wire logic [3:0]   s_axi_araddr,
  input  wire logic         s_axi_arvalid,
  output logic              s_axi_arready,
  output logic [31:0]       s_axi_rdata,
  output logic [1:0]        s_axi_rresp,
  output logic              s_axi_rvalid,
  input  wire logic         s_axi_rready,
  input  wire ivr_fuses_t   fuses,
  input  wire logic         exec_in_boot,
  input  wire logic         instr_retire,
  input  wire logic         global_irq_enable,
  input  wire logic         irq_request,
  input  wire logic [4:0]   vector_index,
  output logic              irq_take,
  output logic              irq_blocked,
  output logic [15:0]       vector_word,
  output logic [15:0]       reset_word
);
  localparam logic [2:0] WIN_LOAD = 3'(WINDOW_CYCLES);

  // Two-stage synchronisers for asynchronous fuse and exec pins
  ivr_fuses_t fuse_s1, fuse_s2;
  logic       boot_s1, boot_s2;
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      fuse_s1 <= '0;
      fuse_s2 <= '0;
      boot_s1 <= 1'b0;
      boot_s2 <= 1'b0;
    end
    else
    begin
      fuse_s1 <= fuses;
      fuse_s2 <= fuse_s1;
      boot_s1 <= exec_in_boot;
      boot_s2 <= boot_s1;
    end
  end

  // Register state
  logic              vector_table_select, next_select;
  logic              vector_change_unlock, next_unlock;
  ivr_unlock_state_t state, next_state;
  logic [2:0]        count, next_count;
  // AXI slave state
  logic              aw_held, next_aw_held, w_held, next_w_held;
  logic [3:0]        aw_addr, next_aw_addr;
  logic [31:0]       w_data, next_w_data;
  logic [3:0]        w_strb, next_w_strb;
  logic              bvalid, next_bvalid, rvalid, next_rvalid;
  logic [1:0]        bresp, next_bresp, rresp, next_rresp;
  logic [31:0]       rdata, next_rdata;
  logic              wr_fire, ctrl_wr;
  logic              wr_unlock, wr_select;
  logic              suppress;
  ivr_vectors_t      map;

  // Write side: address and data taken in any order, one at a time
  always_comb
  begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    wr_fire = aw_held && w_held && !bvalid;
    ctrl_wr = wr_fire && aw_addr == ADDR_MCU_CTRL && w_strb[0];
    if (wr_fire)
    begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (aw_addr == ADDR_MCU_CTRL || aw_addr == ADDR_STATUS
                      || aw_addr == ADDR_EXEC) ? RESP_OKAY : RESP_SLVERR;
    end
    else if (bvalid && s_axi_bready)
      next_bvalid = 1'b0;
  end
  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;

  // Unlock sequence: a write with unlock set opens a timed window
  always_comb
  begin
    wr_unlock   = ctrl_wr && w_data[BIT_UNLOCK];
    wr_select   = ctrl_wr && !w_data[BIT_UNLOCK];
    next_select = vector_table_select;
    next_unlock = vector_change_unlock;
    next_state  = state;
    next_count  = count;
    case (state)
      UNL_IDLE:
      begin
        if (wr_unlock)
        begin
          next_state  = UNL_OPEN;
          next_unlock = 1'b1;
          next_count  = WIN_LOAD;
        end
      end
      UNL_OPEN:
      begin
        if (wr_select)
        begin
          next_select = w_data[BIT_SELECT];
          next_unlock = 1'b0;
          next_state  = UNL_HOLD;
        end
        else if (count == 3'h1)
        begin
          next_unlock = 1'b0;
          next_state  = UNL_IDLE;
        end
        else
          next_count = 3'(count - 3'h1);
      end
      UNL_HOLD:
      begin
        // Keep blocked until the following instruction retires
        if (instr_retire)
          next_state = UNL_IDLE;
      end
      default:
      begin
        next_state  = UNL_IDLE;
        next_unlock = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      vector_table_select  <= MCU_CTRL_RESET[BIT_SELECT];
      vector_change_unlock <= MCU_CTRL_RESET[BIT_UNLOCK];
      state                <= UNL_IDLE;
      count                <= 3'h0;
      aw_held              <= 1'b0;
      aw_addr              <= 4'h0;
      w_held               <= 1'b0;
      w_data               <= 32'h0;
      w_strb               <= 4'h0;
      bvalid               <= 1'b0;
      bresp                <= RESP_OKAY;
      rvalid               <= 1'b0;
      rresp                <= RESP_OKAY;
      rdata                <= 32'h0;
    end
    else
    begin
      vector_table_select  <= next_select;
      vector_change_unlock <= next_unlock;
      state                <= next_state;
      count                <= next_count;
      aw_held              <= next_aw_held;
      aw_addr              <= next_aw_addr;
      w_held               <= next_w_held;
      w_data               <= next_w_data;
      w_strb               <= next_w_strb;
      bvalid               <= next_bvalid;
      bresp                <= next_bresp;
      rvalid               <= next_rvalid;
      rresp                <= next_rresp;
      rdata                <= next_rdata;
    end
  end

  // Section lock suppression; global enable is only read, never written
  always_comb
  begin
    suppress = (vector_table_select && fuse_s2.app_section_lock_bit && !boot_s2)
            || (!vector_table_select && fuse_s2.boot_section_lock_bit && boot_s2);
    irq_blocked = state != UNL_IDLE;
    irq_take    = irq_request && global_irq_enable && !irq_blocked && !suppress;
  end

  // Read side: single outstanding read, data registered
  always_comb
  begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = RESP_OKAY;
      next_rdata  = 32'h0;
      case (s_axi_araddr)
        ADDR_MCU_CTRL:
        begin
          next_rdata[BIT_SELECT] = vector_table_select;
          next_rdata[BIT_UNLOCK] = vector_change_unlock;
        end
        ADDR_STATUS:
        begin
          next_rdata[BIT_BLOCKED]  = irq_blocked;
          next_rdata[BIT_WINDOW]   = state == UNL_OPEN;
          next_rdata[BIT_SUPPRESS] = suppress;
        end
        ADDR_EXEC: next_rdata[BIT_IN_BOOT] = boot_s2;
        default:   next_rresp = RESP_SLVERR;
      endcase
    end
    else if (rvalid && s_axi_rready)
      next_rvalid = 1'b0;
  end
  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  // Address computation lives in the map module
  ivr_vector_map u_map (
    .vector_table_select (vector_table_select),
    .fuses               (fuse_s2),
    .vector_index        (vector_index),
    .map                 (map),
    .vector_word         (vector_word)
  );
  assign reset_word = map.reset_word;

  // Named steps of the unlock sequence
  sequence unlock_write_s;
    wr_unlock && state == UNL_IDLE;
  endsequence
  sequence blocked_window_s;
    irq_blocked [*4];
  endsequence

  block_on_unlock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_write_s |=> irq_blocked)
    else $error("interrupts not blocked after unlock");
  release_four_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_write_s ##1 (!wr_select [*4]) |=> !irq_blocked)
    else $error("interrupts not released after four cycles");
  hold_blocked_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (unlock_write_s ##1 !wr_select) |-> ##0 blocked_window_s or ##1 wr_select)
    else $error("block window cut short");
  unlock_clear_a: assert property (@(posedge aclk) disable iff (!aresetn)
    unlock_write_s |=> ##[1:4] !vector_change_unlock)
    else $error("unlock bit not self-cleared");
  select_lock_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state != UNL_OPEN) |=> $stable(vector_table_select))
    else $error("select changed without unlock");
  select_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (state == UNL_OPEN && wr_select) |=> vector_table_select == $past(w_data[BIT_SELECT])
      && !vector_change_unlock)
    else $error("select write not applied");
  app_suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (vector_table_select && fuse_s2.app_section_lock_bit && !boot_s2) |-> !irq_take)
    else $error("interrupt taken in locked app section");
  boot_suppress_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!vector_table_select && fuse_s2.boot_section_lock_bit && boot_s2) |-> !irq_take)
    else $error("interrupt taken in locked boot section");
  vector_base_a: assert property (@(posedge aclk) disable iff (!aresetn)
    map.vector_base == (vector_table_select ? 16'(map.boot_start + VEC_FIRST_OFS)
                                            : VEC_FIRST_OFS))
    else $error("vector base wrong");
endmodule

/* ivr_pkg.sv */
// Package for the interrupt vector relocation block.
// Assumes a 25 MHz core clock and AXI4-Lite register access.
package ivr_pkg;
  localparam int unsigned CLK_PERIOD_NS  = 40;
  localparam int unsigned UNLOCK_CYCLES  = 4;
  // Register byte addresses
  localparam logic [3:0]  ADDR_MCU_CTRL  = 4'h0;
  localparam logic [3:0]  ADDR_STATUS    = 4'h4;
  localparam logic [3:0]  ADDR_EXEC      = 4'h8;
  // Control register field positions
  localparam int unsigned BIT_UNLOCK     = 0;
  localparam int unsigned BIT_SELECT     = 1;
  // Status register field positions
  localparam int unsigned BIT_BLOCKED    = 0;
  localparam int unsigned BIT_WINDOW     = 1;
  localparam int unsigned BIT_SUPPRESS   = 2;
  // Exec register field: core is running from the boot section
  localparam int unsigned BIT_IN_BOOT    = 0;
  localparam logic [7:0]  MCU_CTRL_RESET = 8'h00;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;
  localparam logic [15:0] APP_RESET_WORD = 16'h0000;
  localparam logic [15:0] VEC_FIRST_OFS  = 16'h0002;
  localparam logic [15:0] VEC_STRIDE     = 16'h0002;
  localparam logic [15:0] FLASH_WORDS    = 16'h4000;
  // Boot section size in words per fuse code 00..11
  localparam logic [15:0] BOOT_WORDS_00  = 16'h0800;
  localparam logic [15:0] BOOT_WORDS_01  = 16'h0400;
  localparam logic [15:0] BOOT_WORDS_10  = 16'h0200;
  localparam logic [15:0] BOOT_WORDS_11  = 16'h0100;

  typedef enum logic [1:0] {
    UNL_IDLE = 2'b00,
    UNL_OPEN = 2'b01,
    UNL_HOLD = 2'b10
  } ivr_unlock_state_t;

  typedef struct packed {
    logic        boot_reset_fuse;
    logic [1:0]  boot_size_fuses;
    logic        app_section_lock_bit;
    logic        boot_section_lock_bit;
  } ivr_fuses_t;

  typedef struct packed {
    logic [15:0] reset_word;
    logic [15:0] vector_base;
    logic [15:0] boot_start;
  } ivr_vectors_t;

  // Boot section start word from the size fuses
  function automatic logic [15:0] ivr_boot_start(input logic [1:0] size);
    logic [15:0] words;
    words = BOOT_WORDS_00;
    case (size)
      2'b00:   words = BOOT_WORDS_00;
      2'b01:   words = BOOT_WORDS_01;
      2'b10:   words = BOOT_WORDS_10;
      default: words = BOOT_WORDS_11;
    endcase
    return 16'(FLASH_WORDS - words);
  endfunction
endpackage

/* ivr_vector_map.sv */
// Vector placement: reset word, vector table base, boot start.
// Assumes fuses are static after reset; purely combinational.
`timescale 1ns/1ns
module ivr_vector_map
  import ivr_pkg::*;
(
  input  wire logic         vector_table_select,
  input  wire ivr_fuses_t   fuses,
  input  wire logic [4:0]   vector_index,
  output ivr_vectors_t      map,
  output logic [15:0]       vector_word
);
  logic [15:0] boot_start;

  // Table base follows the select bit; reset word follows the fuse
  always_comb
  begin
    boot_start      = ivr_boot_start(fuses.boot_size_fuses);
    map.boot_start  = boot_start;
    map.reset_word  = fuses.boot_reset_fuse ? APP_RESET_WORD : boot_start;
    map.vector_base = vector_table_select ? 16'(boot_start + VEC_FIRST_OFS)
                                          : VEC_FIRST_OFS;
    // Vector n (1-based) sits 2(n-1) words above the base, vectors two words apart
    vector_word     = 16'(map.vector_base + 16'(vector_index) * VEC_STRIDE
                          - VEC_STRIDE);
  end
endmodule

/* test_interrupt_vector_relocation.sv */
// Self-checking bench for the vector relocation block: bus, unlock, gating.
// Assumes ivr_pkg and ivr_top are compiled first; the bench drives every port.
`timescale 1ns/1ns
module test_interrupt_vector_relocation
  import ivr_pkg::*;
;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [3:0]  awaddr, araddr, wstrb;
  logic [31:0] wdata, rdata, rd;
  logic [1:0]  bresp, rresp, resp;
  ivr_fuses_t  fuses;
  logic        in_boot, retire, gie, irq_req, irq_take, irq_blocked;
  logic [4:0]  vidx;
  logic [15:0] vword, rword;
  int          fails = 0;
  int          checks = 0;
  int          blk_run = 0;
  int          blk_last = 0;

  ivr_top #(.WINDOW_CYCLES(UNLOCK_CYCLES)) u_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fuses(fuses),
    .exec_in_boot(in_boot), .instr_retire(retire), .global_irq_enable(gie),
    .irq_request(irq_req), .vector_index(vidx), .irq_take(irq_take),
    .irq_blocked(irq_blocked), .vector_word(vword), .reset_word(rword)
  );

  // Free-running clock, 25 MHz
  initial
  begin
    aclk = 1'b0;
    forever #(CLK_PERIOD_NS / 2) aclk = ~aclk;
  end

  // Length of the last blocked stretch, in sampled cycles
  always @(posedge aclk)
  begin
    if (irq_blocked === 1'b1)
      blk_run <= blk_run + 1;
    else
    begin
      if (blk_run != 0)
        blk_last <= blk_run;
      blk_run <= 0;
    end
  end

  task automatic complete_run;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %0t %s got %0h exp %0h", $time, what, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Both write halves offered together; each released once taken
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic ad;
    logic wd;
    ad = 1'b0;
    wd = 1'b0;
    awaddr <= a;
    wdata <= {24'h000000, d};
    wstrb <= 4'hF;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ad && wd))
    begin
      @(posedge aclk);
      if (!ad && awready === 1'b1)
      begin
        ad = 1'b1;
        awvalid <= 1'b0;
      end
      if (!wd && wready === 1'b1)
      begin
        wd = 1'b1;
        wvalid <= 1'b0;
      end
    end
    // Response ready stays high after the answer; each call drives it high again
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
  endtask

  task automatic rdr(input logic [3:0] a);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    resp = rresp;
  endtask

  task automatic vec(input logic [4:0] idx, input logic [15:0] exp);
    vidx <= idx;
    @(posedge aclk);
    chk(vword, exp, "vector word");
  endtask

  task automatic pulse_retire;
    retire <= 1'b1;
    @(posedge aclk);
    retire <= 1'b0;
    cyc(2);
  endtask

  // Full unlock-then-select sequence, back to back
  task automatic set_sel(input logic v);
    wr(ADDR_MCU_CTRL, 8'h01);
    wr(ADDR_MCU_CTRL, {6'h00, v, 1'b0});
    pulse_retire();
  endtask

  task automatic t_reset;
    rdr(ADDR_MCU_CTRL);
    chk(rd[7:0], MCU_CTRL_RESET, "ctrl after reset");
    rdr(ADDR_STATUS);
    chk(rd[2:0], 3'h0, "status after reset");
    rdr(4'hC);
    chk(resp, RESP_SLVERR, "unmapped read");
    wr(4'hC, 8'h03);
    chk(resp, RESP_SLVERR, "unmapped write");
    vec(5'h01, 16'h0002);
    chk(rword, APP_RESET_WORD, "reset word");
    chk(irq_take, 1'b1, "take while idle");
    gie <= 1'b0;
    cyc(1);
    chk(irq_take, 1'b0, "no take with enable low");
    gie <= 1'b1;
  endtask

  task automatic t_move;
    wr(ADDR_MCU_CTRL, 8'h01);
    chk(resp, RESP_OKAY, "unlock write");
    chk(irq_blocked, 1'b1, "blocked on unlock");
    chk(irq_take, 1'b0, "no take on unlock");
    wr(ADDR_MCU_CTRL, 8'h02);
    cyc(6);
    chk(irq_blocked, 1'b1, "held until retire");
    pulse_retire();
    chk(irq_blocked, 1'b0, "released by retire");
    rdr(ADDR_MCU_CTRL);
    chk(rd[7:0], 8'h02, "select set, unlock gone");
    vec(5'h01, 16'h3C02);
    vec(5'h19, 16'h3C32);
    chk(rword, 16'h0000, "reset word stays");
  endtask

  // Window lapses with no select write; later select write is ignored
  task automatic t_lapse;
    wr(ADDR_MCU_CTRL, 8'h01);
    cyc(8);
    chk(blk_last, UNLOCK_CYCLES, "block length");
    rdr(ADDR_MCU_CTRL);
    chk(rd[7:0], 8'h02, "unlock self-cleared");
    wr(ADDR_MCU_CTRL, 8'h00);
    rdr(ADDR_MCU_CTRL);
    chk(rd[7:0], 8'h02, "locked select kept");
    chk(irq_blocked, 1'b0, "no block from plain write");
  endtask

  // Lock bits gate by execution section; sync needs a few cycles
  task automatic t_locks;
    fuses.app_section_lock_bit <= 1'b1;
    cyc(5);
    chk(irq_take, 1'b0, "app run, boot vectors");
    in_boot <= 1'b1;
    cyc(5);
    chk(irq_take, 1'b1, "boot run, boot vectors");
    set_sel(1'b0);
    fuses.app_section_lock_bit <= 1'b0;
    fuses.boot_section_lock_bit <= 1'b1;
    cyc(5);
    chk(irq_take, 1'b0, "boot run, app vectors");
    in_boot <= 1'b0;
    cyc(5);
    chk(irq_take, 1'b1, "app run, app vectors");
    fuses.boot_reset_fuse <= 1'b0;
    cyc(5);
    chk(rword, 16'h3C00, "boot reset word");
    vec(5'h01, 16'h0002);
  endtask

  // Every boot size code, vectors relocated
  task automatic t_sizes;
    logic [15:0] words [4];
    words = '{BOOT_WORDS_00, BOOT_WORDS_01, BOOT_WORDS_10, BOOT_WORDS_11};
    set_sel(1'b1);
    for (int k = 0; k < 4; k++)
    begin
      fuses.boot_size_fuses <= 2'(k);
      cyc(5);
      vec(5'h03, 16'(FLASH_WORDS - words[k] + 16'h0006));
      chk(rword, 16'(FLASH_WORDS - words[k]), "reset at boot start");
    end
  endtask

  initial
  begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = 6'h00;
    {awaddr, araddr, wstrb, wdata} = 44'h0;
    fuses = '{1'b1, 2'b01, 1'b0, 1'b0};
    {in_boot, retire} = 2'b00;
    {gie, irq_req} = 2'b11;
    vidx = 5'h01;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(2);
    t_reset();
    t_move();
    t_lapse();
    t_locks();
    t_sizes();
    complete_run();
  end

  // Hang guard at 20000 cycles, far beyond the under 200 cycles the tests need
  initial
  begin
    #(CLK_PERIOD_NS * 20000);
    fails++;
    complete_run();
  end
endmodule
